// file: inc/irq_pkg.sv
package irq_pkg;

  // register addresses (byte addresses as printed)
  localparam logic [12:0] enable_low_addr     = 13'h0008;
  localparam logic [12:0] pending_low_addr    = 13'h0009;
  localparam logic [12:0] pending_high_addr   = 13'h0012;
  localparam logic [12:0] enable_high_addr    = 13'h0013;
  localparam logic [12:0] event_enable_w_addr = 13'h1fa0;
  localparam logic [12:0] event_pending_w_addr = 13'h1fa2;
  localparam logic [12:0] event_enable_b_addr = 13'h1fa4;
  localparam logic [12:0] event_pending_b_addr = 13'h1fa6;
  localparam logic [12:0] priority_code_addr  = 13'h1fa8;

  // reset values
  localparam logic [7:0]  byte_reset  = 8'h00;
  localparam logic [19:0] event_reset = 20'h00000;

  // bit positions
  localparam int mux_event_bit = 0;  // multiplexed event in low bank
  localparam int nmi_bit       = 7;  // nonmaskable in high bank

  // vector bases, two bytes per bit step
  localparam logic [15:0] low_vector_base  = 16'h2000;
  localparam logic [15:0] high_vector_base = 16'h2030;

  // priority code for "none"
  localparam logic [4:0] code_none = 5'h00;

  // register bus request carrier
  typedef struct packed {
    logic [12:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_type;

  // core vector dispatch carrier
  typedef struct packed {
    logic        take;    // core takes a vector this cycle
    logic [15:0] vector;  // vector being taken
  } take_type;

  // core instruction strobes
  typedef struct packed {
    logic push_flags;
    logic push_all;
    logic pop_flags;
    logic pop_all;
    logic irq_on;
    logic irq_off;
    logic boundary;
  } core_op_type;

endpackage : irq_pkg

// file: rtl/irq_ctrl.sv
// Overview of operation
// - hardware request sets matching pending bit
// - vector taken clears its pending bit, except the mux bit
// - software pending write acts as request
// - high bank vectors 203EH down to 2030H
// - nonmaskable always enabled, mask bit ignored
// - push saves and clears low mask; pop restores
// - no interrupt right after push
// - global enable gates all maskable interrupts
// - push all saves high mask, pop all restores
// - mux event from channels, overruns, timers
// - event masks select, pending show cause
// - priority code 01H..14H, 00H if none
// - codes descend channels, overruns, compares, timers
// - priority read clears returned source pending
// - no event pending clears mux pending bit
// - CAN requests merge into one input
// - event mask plus low mask bit 0
// - detected event sets its event pending bit
//
// The implementer's own choice: the address-and-strobe port.
module irq_ctrl (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  // register port
  input  wire irq_pkg::bus_req_type bus_req,
  output logic [15:0]               rdata,
  // peripheral requests, one-cycle pulses from core clock logic
  input  wire logic [7:1]           low_req,
  input  wire logic [7:0]           high_req,
  input  wire logic [19:0]          event_req,
  // core side
  input  wire irq_pkg::take_type    take,
  input  wire irq_pkg::core_op_type core_op,
  input  wire logic [15:0]          pop_data,
  output logic [15:0]               push_data,
  output logic                      irq_valid,
  output logic [15:0]               irq_vector,
  output logic [4:0]                priority_code
);

  // register state
  logic [7:0]  enable_low_q;     // low mask, low byte of status word
  logic [7:0]  enable_high_q;    // high mask
  logic [7:0]  pending_low_q;    // low pending
  logic [7:0]  pending_high_q;   // high pending
  logic [19:0] event_enable_q;   // [19:4] word, [3:0] byte
  logic [19:0] event_pending_q;  // same layout
  logic        global_on_q;      // global enable
  logic        hold_q;           // blocks the boundary after a push

  // decoded strobes
  logic wr_en_low, wr_en_high, wr_pend_low, wr_pend_high;
  logic wr_ev_w, wr_ev_b, wr_evp_w, wr_evp_b, rd_code;
  assign wr_en_low   = bus_req.wr && bus_req.addr == irq_pkg::enable_low_addr;
  assign wr_en_high  = bus_req.wr &&
                       bus_req.addr == irq_pkg::enable_high_addr;
  assign wr_pend_low = bus_req.wr &&
                       bus_req.addr == irq_pkg::pending_low_addr;
  assign wr_pend_high = bus_req.wr &&
                        bus_req.addr == irq_pkg::pending_high_addr;
  assign wr_ev_w  = bus_req.wr && bus_req.addr == irq_pkg::event_enable_w_addr;
  assign wr_ev_b  = bus_req.wr && bus_req.addr == irq_pkg::event_enable_b_addr;
  assign wr_evp_w = bus_req.wr &&
                    bus_req.addr == irq_pkg::event_pending_w_addr;
  assign wr_evp_b = bus_req.wr &&
                    bus_req.addr == irq_pkg::event_pending_b_addr;
  assign rd_code  = bus_req.rd && bus_req.addr == irq_pkg::priority_code_addr;

  // enabled event sources and priority encoder
  logic [19:0] event_active;
  logic [4:0]  code_now;
  logic [19:0] code_clear;
  assign event_active = event_pending_q & event_enable_q;

  // bit 19 is channel 4 (code 14H) down to bit 0 timer 2 (code 01H)
  always_comb begin
    code_now   = irq_pkg::code_none;
    code_clear = '0;
    for (int i = 0; i < 20; i++) begin
      if (event_active[i]) begin
        code_now   = 5'(i + 1);
        code_clear = 20'(1) << i;
      end
    end
  end

  logic mux_req;
  assign mux_req = |event_active;

  // take decode: one-hot clear for the vector being taken
  logic [7:0] take_clr_low, take_clr_high;
  always_comb begin
    take_clr_low  = '0;
    take_clr_high = '0;
    for (int b = 0; b < 8; b++) begin
      if (take.take &&
          take.vector == irq_pkg::low_vector_base + 16'(2 * b))
        take_clr_low[b] = 1'b1;
      if (take.take &&
          take.vector == irq_pkg::high_vector_base + 16'(2 * b))
        take_clr_high[b] = 1'b1;
    end
  end

  // low mask: push saves then clears, pop restores
  always_ff @(posedge sys_clk) begin
    if (rst)
      enable_low_q <= irq_pkg::byte_reset;
    else if (core_op.push_flags || core_op.push_all)
      enable_low_q <= irq_pkg::byte_reset;
    else if (core_op.pop_flags || core_op.pop_all)
      enable_low_q <= pop_data[7:0];
    else if (wr_en_low)
      enable_low_q <= bus_req.wdata[7:0];
  end

  // high mask: only the push-all/pop-all pair saves it
  always_ff @(posedge sys_clk) begin
    if (rst)
      enable_high_q <= irq_pkg::byte_reset;
    else if (core_op.pop_all)
      enable_high_q <= pop_data[15:8];
    else if (wr_en_high)
      enable_high_q <= bus_req.wdata[7:0];
  end

  // push image: low mask in the low byte, high mask above it for push all only (zero for push flags), captured before clearing
  always_ff @(posedge sys_clk) begin
    if (rst)
      push_data <= 16'h0000;
    else if (core_op.push_flags)
      push_data <= {8'h00, enable_low_q};
    else if (core_op.push_all)
      push_data <= {enable_high_q, enable_low_q};
  end

  // global enable and post-push hold
  always_ff @(posedge sys_clk) begin
    if (rst)
      global_on_q <= 1'b0;
    else if (core_op.irq_on)
      global_on_q <= 1'b1;
    else if (core_op.irq_off)
      global_on_q <= 1'b0;
  end

  // hold lasts until the next instruction boundary has passed
  always_ff @(posedge sys_clk) begin
    if (rst)
      hold_q <= 1'b0;
    else if (core_op.push_flags || core_op.push_all)
      hold_q <= 1'b1;
    else if (core_op.boundary)
      hold_q <= 1'b0;
  end

  // event pending: set wins over any clear
  always_ff @(posedge sys_clk) begin
    if (rst)
      event_pending_q <= irq_pkg::event_reset;
    else begin
      logic [19:0] v;
      v = event_pending_q;
      if (wr_evp_w)
        v[19:4] = bus_req.wdata;
      if (wr_evp_b)
        v[3:0] = bus_req.wdata[3:0];
      if (rd_code)
        v = v & ~code_clear;
      event_pending_q <= v | event_req;
    end
  end

  // event enables; reserved upper byte bits stay zero
  always_ff @(posedge sys_clk) begin
    if (rst)
      event_enable_q <= irq_pkg::event_reset;
    else begin
      if (wr_ev_w)
        event_enable_q[19:4] <= bus_req.wdata;
      if (wr_ev_b)
        event_enable_q[3:0] <= bus_req.wdata[3:0];
    end
  end

  // low pending: hardware and software sets win over take clear
  always_ff @(posedge sys_clk) begin
    if (rst)
      pending_low_q <= irq_pkg::byte_reset;
    else begin
      logic [7:0] p;
      p = pending_low_q & ~take_clr_low;
      if (wr_pend_low)
        p = bus_req.wdata[7:0];
      p[7:1] = p[7:1] | low_req;
      // mux bit follows enabled event state; a take keeps it if
      // other sources remain
      p[irq_pkg::mux_event_bit] = mux_req ||
        (wr_pend_low && bus_req.wdata[irq_pkg::mux_event_bit]);
      pending_low_q <= p;
    end
  end

  // high pending; the CAN bit is a single merged input
  always_ff @(posedge sys_clk) begin
    if (rst)
      pending_high_q <= irq_pkg::byte_reset;
    else begin
      logic [7:0] p;
      p = pending_high_q & ~take_clr_high;
      if (wr_pend_high)
        p = bus_req.wdata[7:0];
      pending_high_q <= p | high_req;
    end
  end

  // selection: nonmaskable first, then high bank, then low bank
  logic [7:0]  act_low, act_high;
  logic        sel_valid;
  logic [15:0] sel_vector;
  always_comb begin
    act_low  = pending_low_q & enable_low_q;
    act_high = pending_high_q & enable_high_q;
    act_high[irq_pkg::nmi_bit] = pending_high_q[irq_pkg::nmi_bit];
    if (!global_on_q) begin
      act_low = '0;
      act_high[6:0] = '0;
    end
    sel_valid  = 1'b0;
    sel_vector = 16'h0000;
    for (int k = 0; k < 8; k++) begin
      if (act_low[k]) begin
        sel_valid  = 1'b1;
        sel_vector = irq_pkg::low_vector_base + 16'(2 * k);
      end
    end
    for (int k = 0; k < 8; k++) begin
      if (act_high[k]) begin
        sel_valid  = 1'b1;
        sel_vector = irq_pkg::high_vector_base + 16'(2 * k);
      end
    end
  end

  // request to the core, withheld during the post-push boundary
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_valid  <= 1'b0;
      irq_vector <= 16'h0000;
    end else begin
      irq_valid  <= sel_valid && !hold_q &&
                    !core_op.push_flags && !core_op.push_all;
      irq_vector <= sel_vector;
    end
  end

  // priority code output and read data
  always_ff @(posedge sys_clk) begin
    if (rst)
      priority_code <= irq_pkg::code_none;
    else
      priority_code <= code_now;
  end

  always_ff @(posedge sys_clk) begin
    if (rst)
      rdata <= 16'h0000;
    else if (bus_req.rd) begin
      unique case (bus_req.addr)
        irq_pkg::enable_low_addr:      rdata <= {8'h00, enable_low_q};
        irq_pkg::enable_high_addr:     rdata <= {8'h00, enable_high_q};
        irq_pkg::pending_low_addr:     rdata <= {8'h00, pending_low_q};
        irq_pkg::pending_high_addr:    rdata <= {8'h00, pending_high_q};
        irq_pkg::event_enable_w_addr:  rdata <= event_enable_q[19:4];
        irq_pkg::event_enable_b_addr:  rdata <= {12'h000, event_enable_q[3:0]};
        irq_pkg::event_pending_w_addr: rdata <= event_pending_q[19:4];
        irq_pkg::event_pending_b_addr:
          rdata <= {12'h000, event_pending_q[3:0]};
        irq_pkg::priority_code_addr:   rdata <= {11'h000, code_now};
        default:                       rdata <= 16'h0000;
      endcase
    end
  end

  // checks, all on the core clock and quiet during reset
  push_clears_a: assert property (@(posedge sys_clk)
    disable iff (rst)
    (core_op.push_flags || core_op.push_all) |=> enable_low_q == 8'h00)
    else $error("low mask not cleared by push");
  pop_restore_a: assert property (@(posedge sys_clk)
    disable iff (rst)
    core_op.pop_all |=> enable_high_q == $past(pop_data[15:8]))
    else $error("high mask not restored by pop all");
  push_hold_a: assert property (@(posedge sys_clk)
    disable iff (rst)
    (core_op.push_flags || core_op.push_all) |=> !irq_valid)
    else $error("interrupt right after push");
  // the hold outlasts the push cycle until a boundary is seen
  hold_block_a: assert property (@(posedge sys_clk)
    disable iff (rst)
    hold_q |=> !irq_valid)
    else $error("interrupt during post-push hold");
  read_clear_a: assert property (@(posedge sys_clk)
    disable iff (rst)
    (rd_code && code_now != 5'h00 && event_req == 20'h0 && !wr_evp_w
     && !wr_evp_b) |=> !event_pending_q[$past(code_now) - 5'h01])
    else $error("priority read did not clear source");
  code_range_a: assert property (@(posedge sys_clk)
    disable iff (rst)
    priority_code <= 5'h14)
    else $error("priority code out of range");
  code_none_a: assert property (@(posedge sys_clk)
    disable iff (rst)
    (event_active == 20'h0) |=> priority_code == irq_pkg::code_none)
    else $error("priority code set with no active source");
  // channel 4 outranks every other multiplexed source
  code_top_a: assert property (@(posedge sys_clk)
    disable iff (rst)
    event_active[19] |=> priority_code == 5'h14)
    else $error("channel 4 not given the top code");
  mux_follow_a: assert property (@(posedge sys_clk)
    disable iff (rst)
    (mux_req && !rd_code) |=> pending_low_q[0])
    else $error("mux pending not held");
  mux_clear_a: assert property (@(posedge sys_clk)
    disable iff (rst)
    (!mux_req && !wr_pend_low && !(|event_req)) |=> !pending_low_q[0])
    else $error("mux pending not cleared");
  req_set_a: assert property (@(posedge sys_clk)
    disable iff (rst)
    (|high_req) |=> ((pending_high_q & $past(high_req)) == $past(high_req)))
    else $error("request not latched");
  low_set_a: assert property (@(posedge sys_clk)
    disable iff (rst)
    (|low_req) |=> ((pending_low_q[7:1] & $past(low_req)) == $past(low_req)))
    else $error("low bank request not latched");
  sw_pend_a: assert property (@(posedge sys_clk)
    disable iff (rst)
    wr_pend_high |=> ((pending_high_q & $past(bus_req.wdata[7:0]))
                      == $past(bus_req.wdata[7:0])))
    else $error("software pending write lost");
  mask_gate_a: assert property (@(posedge sys_clk)
    disable iff (rst)
    ((pending_low_q & enable_low_q) == 8'h00 && !pending_high_q[7]
     && (pending_high_q & enable_high_q) == 8'h00) |=> !irq_valid)
    else $error("masked source presented");
  global_off_a: assert property (@(posedge sys_clk)
    disable iff (rst)
    (!global_on_q && !pending_high_q[7]) |=> !irq_valid)
    else $error("maskable taken while globally off");
  nmi_pass_a: assert property (@(posedge sys_clk)
    disable iff (rst)
    (pending_high_q[irq_pkg::nmi_bit] && !hold_q && !core_op.push_flags
     && !core_op.push_all) |=> (irq_valid && irq_vector == 16'h203e))
    else $error("nonmaskable request not presented");
  take_clear_a: assert property (@(posedge sys_clk)
    disable iff (rst)
    (take.take && take.vector == 16'h2032 && !high_req[1] && !wr_pend_high)
    |=> !pending_high_q[1])
    else $error("taken vector pending not cleared");

  push_cov: cover property (@(posedge sys_clk) core_op.push_all);
  code_cov: cover property (@(posedge sys_clk) rd_code && code_now != 5'h00);
  irq_cov:  cover property (@(posedge sys_clk) irq_valid && take.take);
  hold_cov: cover property (@(posedge sys_clk) hold_q && sel_valid);
  nmi_cov:  cover property (@(posedge sys_clk) irq_vector == 16'h203e);

endmodule : irq_ctrl

// file: tb/core_model.sv
// core dispatch: fetches a vector after the request has stood a while
module core_model (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // bench controls: dispatch on, extra wait cycles
  input  wire logic        en,
  input  wire logic [3:0]  lat,
  // request from the controller
  input  wire logic        irq_valid,
  input  wire logic [15:0] irq_vector,
  // vector fetch back
  output irq_pkg::take_type take
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [3:0] wait_q;  // cycles the request has stood

  // two spare cycles let the registered request fall after a fetch,
  // so a stale level is never fetched twice
  always_ff @(posedge sys_clk) begin
    if (rst || !en || !irq_valid || take.take) begin
      wait_q <= 4'h0;
      take   <= '0;
    end else if (wait_q == lat + 4'h2) begin
      take   <= '{take: 1'b1, vector: irq_vector};
      wait_q <= 4'h0;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule : core_model

// file: tb/tb_top.sv
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin \
  err_count++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic                 sys_clk;
  logic                 rst;
  irq_pkg::bus_req_type bus_req;
  logic [15:0]          rdata;
  logic [7:1]           low_req;
  logic [7:0]           high_req;
  logic [19:0]          event_req;
  irq_pkg::take_type    take;
  irq_pkg::core_op_type core_op;
  logic [15:0]          pop_data;
  logic [15:0]          push_data;
  logic                 irq_valid;
  logic [15:0]          irq_vector;
  logic [4:0]           priority_code;
  logic                 en;        // core dispatch on
  logic [3:0]           lat;       // core extra wait
  logic                 took;      // a fetch was seen
  logic [15:0]          last_vec;  // last fetched vector
  int                   err_count;
  int                   checks;

  irq_ctrl uut (.sys_clk(sys_clk), .rst(rst), .bus_req(bus_req),
    .rdata(rdata), .low_req(low_req), .high_req(high_req),
    .event_req(event_req), .take(take), .core_op(core_op),
    .pop_data(pop_data), .push_data(push_data), .irq_valid(irq_valid),
    .irq_vector(irq_vector), .priority_code(priority_code));
  core_model partner (.sys_clk(sys_clk), .rst(rst), .en(en), .lat(lat),
    .irq_valid(irq_valid), .irq_vector(irq_vector), .take(take));

  // clock
  always #10 sys_clk = ~sys_clk;
  // fetch log
  always @(posedge sys_clk) begin
    if (take.take) begin
      took     <= 1'b1;
      last_vec <= take.vector;
    end
  end

  // one-cycle write
  task automatic wr(input logic [12:0] a, input logic [15:0] v);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
  endtask : wr
  // one-cycle read, data compared in the following cycle only
  task automatic rd(input logic [12:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
    #1;
    `CHK($sformatf("rd %h", a), e, rdata)
  endtask : rd
  // peripheral request pulse, then time for it to settle
  task automatic raise(input logic [7:1] l, input logic [7:0] h,
                       input logic [19:0] e);
    @(posedge sys_clk);
    low_req   <= l;
    high_req  <= h;
    event_req <= e;
    @(posedge sys_clk);
    low_req   <= '0;
    high_req  <= '0;
    event_req <= '0;
    repeat (2) @(posedge sys_clk);
  endtask : raise
  // core instruction pulse: 40 push flags, 20 push all, 10 pop flags,
  // 08 pop all, 04 global on, 02 global off
  task automatic op(input logic [6:0] v);
    @(posedge sys_clk);
    core_op <= v;
    @(posedge sys_clk);
    core_op <= '0;
    #1;
  endtask : op
  // bounded wait for a fetch
  task automatic wait_take(input logic [15:0] e);
    for (int i = 0; i < 40 && !took; i++) @(posedge sys_clk);
    `CHK("vector", {1'b1, e}, {took, last_vec})
    took = 1'b0;
  endtask : wait_take
  task automatic no_take();
    repeat (20) @(posedge sys_clk);
    `CHK("no fetch", 1'b0, took)
  endtask : no_take
  task automatic done(input string n);
    $display("test %s done, %0d mismatches", n, err_count);
  endtask : done
  task automatic results();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  // watchdog at 20000 cycles, well beyond the few hundred cycles the tests take
  initial begin
    #400000;
    err_count++;
    results();
  end

  initial begin
    logic [12:0] regs [5];
    bit          hi;
    int          b;
    logic [15:0] ev;
    regs = '{irq_pkg::enable_low_addr, irq_pkg::pending_low_addr,
      irq_pkg::pending_high_addr, irq_pkg::enable_high_addr,
      irq_pkg::priority_code_addr};
    sys_clk = 1'b0;
    rst = 1'b1;
    bus_req = '0;
    {low_req, high_req, event_req, core_op} = '0;
    {pop_data, en, lat, took, last_vec} = '0;
    err_count = 0;
    checks = 0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    // reset values, unmapped and read-only places
    foreach (regs[i]) rd(regs[i], 16'h0000);
    wr(13'h0050, 16'h00ff);
    rd(13'h0050, 16'h0000);
    wr(irq_pkg::priority_code_addr, 16'h001f);
    rd(irq_pkg::priority_code_addr, 16'h0000);
    wr(irq_pkg::enable_high_addr, 16'h005a);
    rd(irq_pkg::enable_high_addr, 16'h005a);
    raise(7'h08, 8'h04, 20'h0);
    rd(irq_pkg::pending_low_addr, 16'h0010);
    rd(irq_pkg::pending_high_addr, 16'h0004);
    wr(irq_pkg::pending_low_addr, 16'h0000);
    wr(irq_pkg::pending_high_addr, 16'h0000);
    done("registers");
    // software-set pending per source; mask bit 7 high is never written
    en = 1'b1;
    op(7'h04);
    for (int i = 0; i < 14; i++) begin
      hi = i > 6;
      b = hi ? i - 7 : i + 1;
      wr(hi ? irq_pkg::enable_high_addr : irq_pkg::enable_low_addr,
         16'(1 << b));
      took = 1'b0;
      wr(hi ? irq_pkg::pending_high_addr : irq_pkg::pending_low_addr,
         16'(1 << b));
      ev = (hi ? 16'h2030 : 16'h2000) + 16'(2 * b);
      wait_take(ev);
      rd(hi ? irq_pkg::pending_high_addr : irq_pkg::pending_low_addr,
         16'h0000);
    end
    done("vectors");
    // individual mask, global gate, nonmaskable with a slow core
    wr(irq_pkg::enable_high_addr, 16'h0000);
    wr(irq_pkg::enable_low_addr, 16'h0000);
    wr(irq_pkg::pending_low_addr, 16'h0010);
    no_take();
    op(7'h02);
    wr(irq_pkg::enable_low_addr, 16'h0010);
    no_take();
    op(7'h04);
    wait_take(16'h2008);
    op(7'h02);
    lat = 4'h5;
    raise(7'h00, 8'h80, 20'h0);
    wait_take(16'h203e);
    lat = 4'h0;
    done("gating");
    // stack save and restore of the masks
    wr(irq_pkg::enable_low_addr, 16'h00c3);
    wr(irq_pkg::enable_high_addr, 16'h003c);
    op(7'h20);
    `CHK("push_data", 16'h3cc3, push_data)
    rd(irq_pkg::enable_low_addr, 16'h0000);
    @(posedge sys_clk);
    pop_data <= 16'h1122;
    op(7'h08);
    rd(irq_pkg::enable_low_addr, 16'h0022);
    rd(irq_pkg::enable_high_addr, 16'h0011);
    op(7'h40);
    rd(irq_pkg::enable_low_addr, 16'h0000);
    @(posedge sys_clk);
    pop_data <= 16'h5566;
    op(7'h10);
    rd(irq_pkg::enable_low_addr, 16'h0066);
    rd(irq_pkg::enable_high_addr, 16'h0011);
    done("stack");
    // a pending source waits out the push hold until the boundary
    op(7'h04);
    wr(irq_pkg::pending_high_addr, 16'h0001);
    no_take();
    op(7'h01);
    wait_take(16'h2030);
    done("push hold");
    // every event source gives its code, a read clears it
    wr(irq_pkg::enable_low_addr, 16'h0000);
    wr(irq_pkg::event_enable_w_addr, 16'hffff);
    wr(irq_pkg::event_enable_b_addr, 16'h000f);
    for (int i = 0; i < 20; i++) begin
      raise(7'h00, 8'h00, 20'(1 << i));
      rd(irq_pkg::priority_code_addr, 16'(i + 1));
      `CHK("priority_code", 5'(i + 1), priority_code)
      rd(irq_pkg::priority_code_addr, 16'h0000);
      `CHK("priority_code", 5'h00, priority_code)
    end
    done("codes");
    // three sources at once through the multiplexed vector
    took = 1'b0;
    op(7'h04);
    wr(irq_pkg::enable_low_addr, 16'h0001);
    raise(7'h00, 8'h00, 20'h82001);
    rd(irq_pkg::event_pending_w_addr, 16'h8200);
    rd(irq_pkg::event_pending_b_addr, 16'h0001);
    wait_take(16'h2000);
    rd(irq_pkg::pending_low_addr, 16'h0001);
    rd(irq_pkg::priority_code_addr, 16'h0014);
    rd(irq_pkg::priority_code_addr, 16'h000e);
    rd(irq_pkg::priority_code_addr, 16'h0001);
    repeat (3) @(posedge sys_clk);
    rd(irq_pkg::pending_low_addr, 16'h0000);
    done("multiplexed");
    // a masked event source stays out of the multiplexed request
    wr(irq_pkg::event_enable_w_addr, 16'h0000);
    raise(7'h00, 8'h00, 20'h80000);
    rd(irq_pkg::pending_low_addr, 16'h0000);
    done("event mask");
    results();
  end
endmodule : tb_top
